// [bench/notch_coeff_and_limiter_regs_bench.sv]
// Self-checking bench for the notch coefficient and limiter register group
`timescale 1ns/1ps
module notch_coeff_and_limiter_regs_bench;
  logic        clk_sys = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
  logic        sample_tick = 1'b0, limiter_enable = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic        waitrequest, notch_filter_on;
  logic [13:0] notch_coefficient_zero, notch_coefficient_one;
  logic [2:0]  threshold_atten_db;
  logic [3:0]  max_boost_db, fixed_boost_db;
  logic [8:0]  v;
  logic [7:0]  pend [4], act [4];
  int          num_errors = 0, num_checks = 0, cycles = 0, i, j, k;
  int          seed = 32'h4d37;

  notch_coeff_and_limiter_regs notch_coeff_and_limiter_regs_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .sample_tick(sample_tick),
    .limiter_enable(limiter_enable), .notch_filter_on(notch_filter_on),
    .notch_coefficient_zero(notch_coefficient_zero), .notch_coefficient_one(notch_coefficient_one),
    .threshold_atten_db(threshold_atten_db), .max_boost_db(max_boost_db), .fixed_boost_db(fixed_boost_db));

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Avalon cycle: hold everything until waitrequest is seen low at an edge, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) check(1'b1, 1'b0);
    @(posedge clk_sys);
  endtask

  function automatic logic [2:0] exp_thr(input logic [2:0] c);
    return (c >= 3'h5) ? 3'h6 : c + 3'h1;
  endfunction

  // Active notch outputs against the bench copy of the active set
  task automatic check_outs();
    check(notch_filter_on, act[0][7]);
    check(notch_coefficient_zero, {act[0][6:0], act[1][6:0]});
    check(notch_coefficient_one, {act[2][6:0], act[3][6:0]});
  endtask

  // Every register reads zero and the outputs sit at their reset levels
  task automatic reset_check();
    for (j = 0; j < 4; j++) begin
      pend[j] = 8'h00;
      act[j] = 8'h00;
      bus(1'b0, 8'h6c + 8'(4 * j), 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b0, 8'h64, 32'h0);
    check(rd, 32'h0);
    check(threshold_atten_db, 3'h1);
    check({max_boost_db, fixed_boost_db}, 8'h00);
    check_outs();
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    reset_check();
    // Limiter codes: every threshold, every legal boost, limiter mode random
    for (i = 0; i < 24; i++) begin
      v = {2'($random(seed)), 3'(i), 4'(i % 13)};
      limiter_enable <= 1'($random(seed));
      bus(1'b1, 8'h64, {23'h0, v});
      @(posedge clk_sys);
      #1;
      check(threshold_atten_db, exp_thr(v[6:4]));
      check(max_boost_db, limiter_enable ? v[3:0] : 4'h0);
      check(fixed_boost_db, limiter_enable ? 4'h0 : v[3:0]);
      @(posedge clk_sys);
      bus(1'b0, 8'h64, 32'h0);
      check(rd, {25'h0, v[6:0]});
    end
    // Staged notch writes, committed by each of the four registers in turn
    for (k = 0; k < 8; k++) begin
      for (j = 0; j < 4; j++) begin
        v = 9'($random(seed));
        v[8] = (j == k % 4);
        if (j == 0) v[7] = k[1];
        if (j != k % 4) bus(1'b1, 8'h6c + 8'(4 * j), {23'h0, v});
        pend[j] = v[7:0];
      end
      v = {1'b1, pend[k % 4]};
      bus(1'b1, 8'h6c + 8'(4 * (k % 4)), {23'h0, v});
      repeat (3) @(posedge clk_sys);
      #1;
      check_outs();
      @(posedge clk_sys);
      sample_tick <= 1'b1;
      @(posedge clk_sys);
      sample_tick <= 1'b0;
      @(posedge clk_sys);
      #1;
      for (j = 0; j < 4; j++) act[j] = pend[j];
      check_outs();
      @(posedge clk_sys);
      bus(1'b0, 8'h6c + 8'(4 * (k % 4)), 32'h0);
      check(rd, {24'h0, (k % 4 == 0) ? pend[0] : {1'b0, pend[k % 4][6:0]}});
    end
    // Unmapped places: writes ignored, reads zero; a misaligned write is ignored
    bus(1'b1, 8'h68, 32'h1ff);
    bus(1'b0, 8'h68, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h6d, 32'h1ff);
    bus(1'b0, 8'h6c, 32'h0);
    check(rd, {24'h0, pend[0]});
    bus(1'b0, 8'h7c, 32'h0);
    check(rd, 32'h0);
    #1;
    check_outs();
    // A sample boundary with no commit waiting leaves the active set alone
    @(posedge clk_sys);
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_outs();
    // Second reset in mid-run clears pending and active sets
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    reset_check();
    results();
  end
endmodule

// [common/notch_regs_pkg.sv]
// Package of offsets, field layouts, reset values and limits for the notch and limiter registers
// Functional notes
// - Threshold code picks limit, 101-111 give -6dB
// - Boost code adds 1dB per step, max 12dB
// - Limiter off: boost applied as fixed gain
// - Update bits are write-only, act on write
// - Update-one write commits all four pending values
// - Update-zero write only stores a pending value
// - Enable bit: zero off, one on
// - Coefficient zero: high half reg one, low reg two
// - Coefficient one: high half reg three, low reg four
package notch_regs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] LIMITER2_IDX   = 6'h19;
  localparam logic [5:0] NOTCH1_IDX     = 6'h1b;
  localparam logic [5:0] NOTCH2_IDX     = 6'h1c;
  localparam logic [5:0] NOTCH3_IDX     = 6'h1d;
  localparam logic [5:0] NOTCH4_IDX     = 6'h1e;
  localparam int         NOTCH_REGS     = 4;
  // Field layout
  localparam int         UPDATE_BIT     = 8;
  localparam int         ENABLE_BIT     = 7;
  localparam int         HALF_W         = 7;
  localparam int         COEF_W         = 14;
  localparam int         THR_LSB        = 4;
  localparam int         THR_W          = 3;
  localparam int         BST_W          = 4;
  localparam int         REG_W          = 9;
  // Reset values
  localparam logic [8:0] LIMITER2_RESET = 9'h000;
  localparam logic [7:0] NOTCH_RESET    = 8'h00;
  // Decode limits
  localparam logic [2:0] THR_FLOOR_CODE = 3'h5;
  localparam logic [2:0] THR_FLOOR_DB   = 3'h6;
  localparam logic [3:0] BST_MAX_CODE   = 4'hc;
endpackage

// [verilog/limiter_decode.sv]
// Decode of the limiter threshold and boost fields into dB figures
`timescale 1ns/1ps
module limiter_decode (
  input  wire logic       clk_sys,            // System clock
  input  wire logic       reset_n,            // Synchronous reset, active low
  input  wire logic [2:0] threshold_code,     // Threshold field
  input  wire logic [3:0] boost_code,         // Boost field
  input  wire logic       limiter_enable,     // Limiter mode from the first limiter register
  output logic      [2:0] threshold_atten_db, // dB below full scale
  output logic      [3:0] max_boost_db,       // Limiter boost ceiling in dB
  output logic      [3:0] fixed_boost_db      // Fixed gain stage when limiter off
);
  // Codes at and above the floor all map to the deepest threshold
  wire [2:0] next_thr = (threshold_code >= notch_regs_pkg::THR_FLOOR_CODE) ?
                        notch_regs_pkg::THR_FLOOR_DB : 3'(threshold_code + 3'h1);
  // Reserved boost codes are clamped so a bad write cannot exceed the ceiling
  wire [3:0] next_bst = (boost_code > notch_regs_pkg::BST_MAX_CODE) ?
                        notch_regs_pkg::BST_MAX_CODE : boost_code;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      threshold_atten_db <= 3'h1;
      max_boost_db       <= 4'h0;
      fixed_boost_db     <= 4'h0;
    end else begin
      threshold_atten_db <= next_thr;
      max_boost_db       <= limiter_enable ? next_bst : 4'h0;
      fixed_boost_db     <= limiter_enable ? 4'h0 : next_bst;
    end
  end
endmodule

// [verilog/notch_coeff_and_limiter_regs.sv]
// Notch coefficient and limiter register group behind an Avalon-MM slave
`timescale 1ns/1ps
module notch_coeff_and_limiter_regs (
  input  wire logic        clk_sys,               // System clock, 200 MHz
  input  wire logic        reset_n,               // Synchronous reset, active low
  input  wire logic [7:0]  address,               // Avalon byte address
  input  wire logic        read,                  // Avalon read request
  input  wire logic        write,                 // Avalon write request
  input  wire logic [31:0] writedata,             // Avalon write data
  output logic      [31:0] readdata,              // Avalon read data
  output logic             waitrequest,           // Avalon wait, low when answered
  input  wire logic        sample_tick,           // One-cycle pulse between audio samples
  input  wire logic        limiter_enable,        // Limiter mode bit held elsewhere
  output logic             notch_filter_on,       // Active notch enable
  output logic      [13:0] notch_coefficient_zero, // Active first coefficient
  output logic      [13:0] notch_coefficient_one,  // Active second coefficient
  output logic      [2:0]  threshold_atten_db,    // Limiter threshold, dB below full scale
  output logic      [3:0]  max_boost_db,          // Limiter boost ceiling in dB
  output logic      [3:0]  fixed_boost_db         // Fixed boost stage in dB
);
  localparam int NR = notch_regs_pkg::NOTCH_REGS;
  localparam int HW = notch_regs_pkg::HALF_W;

  logic       ack;
  logic [8:0] limiter_reg;
  logic       commit_wait;
  logic [7:0] pend  [NR];
  logic [7:0] act   [NR];

  // Address decode
  wire       req        = read | write;
  wire [5:0] idx        = address[7:2];
  wire       aligned    = (address[1:0] == 2'h0);
  wire       sel_lim    = aligned && (idx == notch_regs_pkg::LIMITER2_IDX);
  wire       sel_n1     = aligned && (idx == notch_regs_pkg::NOTCH1_IDX);
  wire       sel_n2     = aligned && (idx == notch_regs_pkg::NOTCH2_IDX);
  wire       sel_n3     = aligned && (idx == notch_regs_pkg::NOTCH3_IDX);
  wire       sel_n4     = aligned && (idx == notch_regs_pkg::NOTCH4_IDX);
  wire [3:0] sel_notch  = {sel_n4, sel_n3, sel_n2, sel_n1};
  wire       bus_wr     = write && ack;
  wire       notch_wr   = bus_wr && (sel_notch != 4'h0);
  wire       update_wr  = notch_wr && writedata[notch_regs_pkg::UPDATE_BIT];
  wire       apply      = sample_tick && commit_wait;

  // Every access waits exactly one cycle; this leaves a cycle to register readdata
  assign waitrequest = req && !ack;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // Notch registers hold only their data bits; the update bit is never stored
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_notch
      notch_stage_reg #(.W(8)) u_stage (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (bus_wr && sel_notch[g]),
        .wr_data ((g == 0) ? writedata[7:0] : {1'b0, writedata[HW-1:0]}),
        .commit  (update_wr),
        .apply   (apply),
        .pending (pend[g]),
        .active  (act[g])
      );
    end
  endgenerate

  // A commit is handed to the filter at the next sample boundary, all four at once
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      commit_wait <= 1'b0;
    end else if (update_wr) begin
      commit_wait <= 1'b1;
    end else if (apply) begin
      commit_wait <= 1'b0;
    end
  end

  // Limiter register, plain read/write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      limiter_reg <= notch_regs_pkg::LIMITER2_RESET;
    end else if (bus_wr && sel_lim) begin
      limiter_reg <= {2'b00, writedata[6:0]};  // Bits 8:7 are reserved and read zero
    end
  end

  // Active parameter outputs; halves joined high then low
  assign notch_filter_on        = act[0][notch_regs_pkg::ENABLE_BIT];
  assign notch_coefficient_zero = {act[0][HW-1:0], act[1][HW-1:0]};
  assign notch_coefficient_one  = {act[2][HW-1:0], act[3][HW-1:0]};

  limiter_decode u_limiter (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .threshold_code     (limiter_reg[notch_regs_pkg::THR_LSB +: notch_regs_pkg::THR_W]),
    .boost_code         (limiter_reg[notch_regs_pkg::BST_W-1:0]),
    .limiter_enable     (limiter_enable),
    .threshold_atten_db (threshold_atten_db),
    .max_boost_db       (max_boost_db),
    .fixed_boost_db     (fixed_boost_db)
  );

  // Read mux; update bit reads zero, unmapped addresses read zero
  wire [8:0] rd_mux = sel_lim ? limiter_reg :
                      sel_n1  ? {1'b0, pend[0]} :
                      sel_n2  ? {1'b0, pend[1]} :
                      sel_n3  ? {1'b0, pend[2]} :
                      sel_n4  ? {1'b0, pend[3]} : 9'h000;

  // Loaded in the waiting cycle so it is stable at the answering edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      readdata <= {23'h000000, rd_mux};
    end
  end

  // ---------------- Assertions ----------------
  sequence notch_commit_s;
    bus_wr && (sel_notch != 4'h0) && writedata[notch_regs_pkg::UPDATE_BIT];
  endsequence

  sequence notch_pend_s;
    bus_wr && (sel_notch != 4'h0) && !writedata[notch_regs_pkg::UPDATE_BIT] && !commit_wait && !sample_tick;
  endsequence

  sequence bus_first_s;
    req && !ack;
  endsequence

  sequence lim_write_s;
    bus_wr && sel_lim;
  endsequence

  sequence notch_read_s;
    read && !ack && (sel_notch != 4'h0);
  endsequence

  sequence commit_tick_s;
    notch_commit_s ##1 sample_tick;
  endsequence

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (req && waitrequest) |=> (!waitrequest || !req))
    else $error("bus request not answered after one wait cycle");

  thresh_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 threshold_atten_db == (($past(limiter_reg[6:4]) >= 3'h5) ? 3'h6 : 3'($past(limiter_reg[6:4]) + 3'h1)))
    else $error("threshold decode wrong");

  boost_max_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (limiter_enable && limiter_reg[3:0] <= 4'hc) |=> max_boost_db == $past(limiter_reg[3:0]))
    else $error("limiter boost ceiling wrong");

  fixed_boost_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !limiter_enable |=> (max_boost_db == 4'h0 &&
      fixed_boost_db == (($past(limiter_reg[3:0]) > 4'hc) ? 4'hc : $past(limiter_reg[3:0]))))
    else $error("fixed boost not applied while limiter off");

  update_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (read && !ack && (sel_notch != 4'h0)) |=> readdata[notch_regs_pkg::UPDATE_BIT] == 1'b0)
    else $error("update bit read back");

  commit_arm_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    notch_commit_s |=> commit_wait)
    else $error("update write did not arm commit");

  commit_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (notch_commit_s ##1 sample_tick) |=> (act[0] == $past(pend[0]) && act[3] == $past(pend[3])))
    else $error("committed values not applied at sample boundary");

  pend_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    notch_pend_s |=> ($stable(notch_coefficient_zero) && $stable(notch_coefficient_one) && !commit_wait))
    else $error("pending write changed active parameters");

  sample_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !sample_tick |=> ($stable(notch_filter_on) && $stable(notch_coefficient_zero) && $stable(notch_coefficient_one)))
    else $error("active parameters changed off a sample boundary");

  coef_join_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    notch_coefficient_zero[13:7] == act[0][6:0] && notch_coefficient_one[6:0] == act[3][6:0])
    else $error("coefficient halves joined wrongly");

  // Bus handshake, read path and unmapped writes
  wait_first_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    bus_first_s |-> waitrequest)
    else $error("first request cycle not held off");

  ack_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ack |=> !ack)
    else $error("acknowledge lasted more than one cycle");

  wait_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !req |-> !waitrequest)
    else $error("waitrequest raised with no request");

  read_stand_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (read && ack) |=> $stable(readdata))
    else $error("read data moved after the answer");

  read_upper_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    readdata[31:9] == 23'h000000)
    else $error("unused read data bits not zero");

  read_unmapped_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (read && !ack && !sel_lim && (sel_notch == 4'h0)) |=> readdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  write_unmapped_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_wr && !sel_lim && (sel_notch == 4'h0)) |=> ($stable(limiter_reg) && $stable(pend[0]) &&
      $stable(pend[1]) && $stable(pend[2]) && $stable(pend[3])))
    else $error("unmapped write changed a register");

  read_lim_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (read && !ack && sel_lim) |=> readdata[8:0] == $past(limiter_reg))
    else $error("limiter read data wrong");

  notch_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    notch_read_s |=> readdata[31:8] == 24'h000000)
    else $error("notch read returned update or reserved bits");

  read_n1_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (read && !ack && sel_n1) |=> readdata[7:0] == $past(pend[0]))
    else $error("first notch read is not the pending value");

  // Limiter register and decode
  lim_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    lim_write_s |=> limiter_reg == {2'b00, $past(writedata[6:0])})
    else $error("limiter write not stored");

  lim_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !(bus_wr && sel_lim) |=> $stable(limiter_reg))
    else $error("limiter register changed without a write");

  thresh_range_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    threshold_atten_db >= 3'h1 && threshold_atten_db <= 3'h6)
    else $error("threshold outside one to six dB");

  boost_ceiling_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    max_boost_db <= 4'hc && fixed_boost_db <= 4'hc)
    else $error("boost above twelve dB");

  boost_clamp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (limiter_enable && limiter_reg[3:0] > 4'hc) |=> max_boost_db == 4'hc)
    else $error("reserved boost code not clamped");

  boost_excl_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    max_boost_db == 4'h0 || fixed_boost_db == 4'h0)
    else $error("ceiling and fixed boost both active");

  fixed_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    limiter_enable |=> fixed_boost_db == 4'h0)
    else $error("fixed boost applied in limiter mode");

  // Pending, commit and active notch sets
  pend_n1_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_wr && sel_n1) |=> pend[0] == $past(writedata[7:0]))
    else $error("first notch write not held pending");

  pend_n2_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_wr && sel_n2) |=> pend[1] == {1'b0, $past(writedata[6:0])})
    else $error("second notch write not held pending");

  pend_n3_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_wr && sel_n3) |=> pend[2] == {1'b0, $past(writedata[6:0])})
    else $error("third notch write not held pending");

  pend_n4_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_wr && sel_n4) |=> pend[3] == {1'b0, $past(writedata[6:0])})
    else $error("fourth notch write not held pending");

  pend_stay_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !bus_wr |=> ($stable(pend[0]) && $stable(pend[1]) && $stable(pend[2]) && $stable(pend[3])))
    else $error("pending value changed without a write");

  commit_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (commit_wait && !sample_tick) |=> commit_wait)
    else $error("waiting commit dropped before a sample boundary");

  commit_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!commit_wait && !update_wr) |=> !commit_wait)
    else $error("commit armed without an update write");

  commit_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (apply && !update_wr) |=> !commit_wait)
    else $error("commit still waiting after it was applied");

  commit_rearm_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (apply && update_wr) |=> commit_wait)
    else $error("update write lost in the apply cycle");

  active_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !apply |=> ($stable(act[0]) && $stable(act[1]) && $stable(act[2]) && $stable(act[3])))
    else $error("active set changed without an applied commit");

  tick_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sample_tick && !commit_wait) |=> ($stable(notch_filter_on) && $stable(notch_coefficient_zero) &&
      $stable(notch_coefficient_one)))
    else $error("sample boundary changed parameters with no commit");

  apply_mid_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    commit_tick_s |=> (act[1] == $past(pend[1]) && act[2] == $past(pend[2])))
    else $error("middle registers not committed");

  enable_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    commit_tick_s |=> notch_filter_on == $past(pend[0][7]))
    else $error("enable not taken from committed value");

  coef0_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    commit_tick_s |=> notch_coefficient_zero == {$past(pend[0][6:0]), $past(pend[1][6:0])})
    else $error("first coefficient not committed");

  coef1_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    commit_tick_s |=> notch_coefficient_one == {$past(pend[2][6:0]), $past(pend[3][6:0])})
    else $error("second coefficient not committed");
endmodule

// [verilog/notch_stage_reg.sv]
// One notch register: pending, committed and active copies
`timescale 1ns/1ps
module notch_stage_reg #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         reset_n,  // Synchronous reset, active low
  input  wire logic         wr_en,    // Bus write to this register
  input  wire logic [W-1:0] wr_data,  // Value written
  input  wire logic         commit,   // Some notch write carried update one
  input  wire logic         apply,    // Sample boundary with a commit waiting
  output logic      [W-1:0] pending,  // Last value written
  output logic      [W-1:0] active    // Value the filter uses
);
  logic [W-1:0] staged;
  wire  [W-1:0] next_pending = wr_en ? wr_data : pending;

  // Commit snapshots the pending value, including this cycle's write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pending <= W'(notch_regs_pkg::NOTCH_RESET);
      staged  <= W'(notch_regs_pkg::NOTCH_RESET);
      active  <= W'(notch_regs_pkg::NOTCH_RESET);
    end else begin
      pending <= next_pending;
      if (commit) begin
        staged <= next_pending;
      end
      if (apply) begin
        active <= staged;
      end
    end
  end
endmodule
